//--- shared/eoc_pkg.sv
// Constants shared by the external oscillator control and status block
package eoc_pkg;

    // ****************************************************************
    // Register map (byte addresses)
    // ****************************************************************
    localparam logic [7:0] ADR_STATUS = 8'h0C;
    localparam logic [7:0] ADR_CONTROL = 8'h10;
    localparam logic [7:0] ADR_INT_STATUS = 8'h14;
    localparam logic [7:0] ADR_INT_MASK = 8'h18;

    // ****************************************************************
    // Control register layout
    // ****************************************************************
    localparam logic [15:0] CTRL_RESET = 16'h0080;
    localparam logic [15:0] CTRL_WMASK = 16'hFFC6;
    localparam int CTRL_SEL_LSB = 12;
    localparam int CTRL_AUTO_GAIN = 11;
    localparam int CTRL_GAIN_LSB = 8;
    localparam int CTRL_RUN_ON_REQ = 7;
    localparam int CTRL_KEEP_STBY = 6;
    localparam int CTRL_CRYSTAL = 2;
    localparam int CTRL_ENABLE = 1;
    localparam int SEL_W = 4;
    localparam int GAIN_W = 3;
    localparam logic [2:0] GAIN_RESET = 3'h0;

    // ****************************************************************
    // Clock source status layout
    // ****************************************************************
    localparam int ST_EXT_OSC_RDY = 0;
    localparam int ST_C32K_RDY = 1;
    localparam int ST_RC32K_RDY = 2;
    localparam int ST_RC8M_RDY = 3;
    localparam int ST_FLL_SYNC = 4;
    localparam int ST_FLL_OOR = 5;
    localparam int ST_FLL_FINE = 6;
    localparam int ST_FLL_COARSE = 7;
    localparam int ST_W = 8;
    localparam logic [7:0] ST_RESET = 8'h00;

    // ****************************************************************
    // Synchronised pin bundle
    // ****************************************************************
    localparam int PIN_ULP = 0;
    localparam int PIN_OSC = 1;
    localparam int PIN_REQ = 2;
    localparam int PIN_STBY = 3;
    localparam int PIN_RC8M = 4;
    localparam int PIN_RC32K = 5;
    localparam int PIN_C32K = 6;
    localparam int PIN_COARSE = 7;
    localparam int PIN_FINE = 8;
    localparam int PIN_OOR = 9;
    localparam int PIN_FSYNC = 10;
    localparam int PIN_W = 11;

    // ****************************************************************
    // Start-up timing
    // ****************************************************************
    localparam int CNT_W = 16;
    localparam logic [1:0] SYNC_CYCLES = 2'h3;

    typedef enum logic [1:0] {
        EOC_COUNT,
        EOC_SYNC,
        EOC_READY
    } eoc_phase_e;

endpackage

//--- design/eoc_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module eoc_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] stable_o
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= async_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Output follows only once stages two and three agree, else holds
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stable_o <= '0;
        end else begin
            stable_o <= (s2_r & s3_r) | (stable_o & (s2_r | s3_r));
        end
    end
endmodule // eoc_sync
`default_nettype wire

//--- design/eoc_settle_count_sel.sv
// Start-up counter and ready synchronisation for the external oscillator
`timescale 1ns/1ps
`default_nettype none
module eoc_settle_count_sel (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic ulp_tick_i,
    input wire logic osc_edge_i,
    input wire logic [eoc_pkg::SEL_W-1:0] sel_i,
    output logic ready_o
);
    eoc_pkg::eoc_phase_e phase_r;
    logic [eoc_pkg::CNT_W-1:0] cnt_r;
    logic [1:0] sync_r;

    function automatic logic [eoc_pkg::CNT_W-1:0] last_count(
        input logic [eoc_pkg::SEL_W-1:0] sel);
        logic [eoc_pkg::CNT_W:0] full;
        full = {{eoc_pkg::CNT_W{1'b0}}, 1'b1} << sel;
        last_count = eoc_pkg::CNT_W'(full - 1'b1);
    endfunction

    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            phase_r <= eoc_pkg::EOC_COUNT; // RULE_17
            cnt_r <= '0; // RULE_17
            sync_r <= '0;
        end else begin
            unique case (phase_r)
                eoc_pkg::EOC_COUNT: begin
                    if (ulp_tick_i) begin
                        cnt_r <= cnt_r + 1'b1;
                        if (cnt_r == last_count(sel_i)) begin // RULE_05
                            phase_r <= eoc_pkg::EOC_SYNC;
                        end
                    end
                end
                eoc_pkg::EOC_SYNC: begin
                    if (osc_edge_i) begin
                        sync_r <= sync_r + 1'b1;
                        if (sync_r == eoc_pkg::SYNC_CYCLES - 1'b1) begin // RULE_06
                            phase_r <= eoc_pkg::EOC_READY;
                        end
                    end
                end
                eoc_pkg::EOC_READY: begin
                    phase_r <= eoc_pkg::EOC_READY;
                end
            endcase
        end
    end

    assign ready_o = (phase_r == eoc_pkg::EOC_READY);
endmodule // eoc_settle_count_sel
`default_nettype wire

//--- design/eoc_top.sv
// External oscillator control, clock source status and bus slave
//
// Contract
// RULE_01: Ready bits 3,2,1 for other oscillators.
// RULE_02: Bit 0 shows external oscillator ready.
// RULE_03: Loop coarse, fine, out-of-range at 7,6,5.
// RULE_04: Bit 4 one when loop sync complete.
// RULE_05: Start-up counts two-to-n slow ticks.
// RULE_06: Then three oscillator edges before ready.
// RULE_07: Bit 11 enables automatic gain control.
// RULE_08: Software sets auto gain after ready.
// RULE_09: Gain field bits 10:8, codes 5-7 reserved.
// RULE_10: Manual gain ignored while auto gain on.
// RULE_11: On-request mode runs only when requested.
// RULE_12: Otherwise runs whenever enabled.
// RULE_13: Standby stops oscillator unless kept.
// RULE_14: Bit 6 keeps oscillator in standby.
// RULE_15: Bit 2 selects crystal or external clock.
// RULE_16: Bit 1 enables the oscillator.
// RULE_17: Stop clears ready, restart counts anew.
// RULE_18: Requests and standby synchronised first.
//
// The Wishbone slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module eoc_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic write_protect_i,
    input wire logic ultra_low_power_32k_i,
    input wire logic osc_in_pin_i,
    input wire logic periph_req_i,
    input wire logic standby_i,
    input wire logic rc8m_ready_i,
    input wire logic rc32k_ready_i,
    input wire logic crystal32k_ready_i,
    input wire logic fll_coarse_lock_i,
    input wire logic fll_fine_lock_i,
    input wire logic fll_out_of_range_i,
    input wire logic fll_sync_ready_i,
    output logic osc_run_o,
    output logic crystal_select_o,
    output logic osc_out_pin_free_o,
    output logic auto_gain_ctrl_o,
    output logic [eoc_pkg::GAIN_W-1:0] osc_gain_o,
    output logic ext_osc_ready_o,
    output logic irq_o
);

    // ****************************************************************
    // Pin synchronisation
    // ****************************************************************
    logic [eoc_pkg::PIN_W-1:0] pins_raw;
    logic [eoc_pkg::PIN_W-1:0] pins;

    always_comb begin
        pins_raw = '0;
        pins_raw[eoc_pkg::PIN_ULP] = ultra_low_power_32k_i;
        pins_raw[eoc_pkg::PIN_OSC] = osc_in_pin_i;
        pins_raw[eoc_pkg::PIN_REQ] = periph_req_i;
        pins_raw[eoc_pkg::PIN_STBY] = standby_i;
        pins_raw[eoc_pkg::PIN_RC8M] = rc8m_ready_i;
        pins_raw[eoc_pkg::PIN_RC32K] = rc32k_ready_i;
        pins_raw[eoc_pkg::PIN_C32K] = crystal32k_ready_i;
        pins_raw[eoc_pkg::PIN_COARSE] = fll_coarse_lock_i;
        pins_raw[eoc_pkg::PIN_FINE] = fll_fine_lock_i;
        pins_raw[eoc_pkg::PIN_OOR] = fll_out_of_range_i;
        pins_raw[eoc_pkg::PIN_FSYNC] = fll_sync_ready_i;
    end

    // Request and standby pass the same synchroniser as the slow clock
    eoc_sync #(
        .W(eoc_pkg::PIN_W)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(pins_raw), // RULE_18
        .stable_o(pins)
    );

    // ****************************************************************
    // Slow clock and oscillator edge enables
    // ****************************************************************
    logic ulp_prev_r;
    logic osc_prev_r;
    logic ulp_tick;
    logic osc_edge;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ulp_prev_r <= 1'b0;
            osc_prev_r <= 1'b0;
        end else begin
            ulp_prev_r <= pins[eoc_pkg::PIN_ULP];
            osc_prev_r <= pins[eoc_pkg::PIN_OSC];
        end
    end

    assign ulp_tick = pins[eoc_pkg::PIN_ULP] && !ulp_prev_r;
    assign osc_edge = pins[eoc_pkg::PIN_OSC] && !osc_prev_r;

    // ****************************************************************
    // Control register
    // ****************************************************************
    logic [15:0] ctrl_r;
    logic bus_req;
    logic bus_take;
    logic wr_take;
    logic rd_take;

    assign bus_req = wb_cyc_i && wb_stb_i;
    assign bus_take = bus_req && !wb_ack_o;
    assign wr_take = bus_take && wb_we_i;
    assign rd_take = bus_take && !wb_we_i;

    function automatic logic hit(input logic [7:0] adr,
                                 input logic [7:0] target);
        hit = (adr == target);
    endfunction

    function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                               input logic [15:0] data,
                                               input logic [1:0] sel,
                                               input logic [15:0] wmask);
        logic [15:0] be;
        be = {{8{sel[1]}}, {8{sel[0]}}} & wmask;
        lane_merge = (old & ~be) | (data & be);
    endfunction

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= eoc_pkg::CTRL_RESET;
        end else if (wr_take && hit(wb_adr_i, eoc_pkg::ADR_CONTROL) &&
                     !write_protect_i) begin
            // Only documented fields are writable
            ctrl_r <= lane_merge(ctrl_r, wb_dat_i[15:0], wb_sel_i[1:0],
                                 eoc_pkg::CTRL_WMASK); // RULE_09
        end
    end

    logic [eoc_pkg::SEL_W-1:0] settle_count_sel;
    logic auto_gain_ctrl;
    logic [eoc_pkg::GAIN_W-1:0] gain_field;
    logic run_on_request;
    logic keep_in_standby;
    logic crystal_select;
    logic osc_enable;

    assign settle_count_sel =
        ctrl_r[eoc_pkg::CTRL_SEL_LSB +: eoc_pkg::SEL_W]; // RULE_05
    assign auto_gain_ctrl = ctrl_r[eoc_pkg::CTRL_AUTO_GAIN];
    assign gain_field = ctrl_r[eoc_pkg::CTRL_GAIN_LSB +: eoc_pkg::GAIN_W];
    assign run_on_request = ctrl_r[eoc_pkg::CTRL_RUN_ON_REQ];
    assign keep_in_standby = ctrl_r[eoc_pkg::CTRL_KEEP_STBY];
    assign crystal_select = ctrl_r[eoc_pkg::CTRL_CRYSTAL];
    assign osc_enable = ctrl_r[eoc_pkg::CTRL_ENABLE];

    // ****************************************************************
    // Run decision
    // ****************************************************************
    logic standby_block;
    logic demand_ok;
    logic osc_run;

    assign standby_block = pins[eoc_pkg::PIN_STBY] && !keep_in_standby; // RULE_13 RULE_14
    assign demand_ok = !run_on_request || pins[eoc_pkg::PIN_REQ]; // RULE_11 RULE_12
    assign osc_run = osc_enable && demand_ok && !standby_block; // RULE_16

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            osc_run_o <= 1'b0;
            crystal_select_o <= 1'b0;
            osc_out_pin_free_o <= 1'b1;
        end else begin
            osc_run_o <= osc_run;
            crystal_select_o <= crystal_select; // RULE_15
            osc_out_pin_free_o <= !crystal_select; // RULE_15
        end
    end

    // ****************************************************************
    // Start-up timing and ready
    // ****************************************************************
    logic ext_ready;

    eoc_settle_count_sel u_settle_count_sel (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(osc_run_o),
        .ulp_tick_i(ulp_tick),
        .osc_edge_i(osc_edge),
        .sel_i(settle_count_sel),
        .ready_o(ext_ready)
    );

    assign ext_osc_ready_o = ext_ready; // RULE_02

    // ****************************************************************
    // Gain control
    // ****************************************************************
    // Auto gain only acts on a running crystal; software sets it after ready
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            auto_gain_ctrl_o <= 1'b0;
        end else begin
            auto_gain_ctrl_o <= auto_gain_ctrl && crystal_select &&
                                osc_run_o; // RULE_07 RULE_08
        end
    end

    // Manual gain frozen while auto gain is active
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            osc_gain_o <= eoc_pkg::GAIN_RESET;
        end else if (!auto_gain_ctrl) begin
            osc_gain_o <= gain_field; // RULE_09 RULE_10
        end
    end

    // ****************************************************************
    // Clock source status
    // ****************************************************************
    logic [eoc_pkg::ST_W-1:0] status;
    logic [eoc_pkg::ST_W-1:0] status_prev_r;

    always_comb begin
        status = eoc_pkg::ST_RESET;
        status[eoc_pkg::ST_EXT_OSC_RDY] = ext_ready; // RULE_02
        status[eoc_pkg::ST_C32K_RDY] = pins[eoc_pkg::PIN_C32K]; // RULE_01
        status[eoc_pkg::ST_RC32K_RDY] = pins[eoc_pkg::PIN_RC32K]; // RULE_01
        status[eoc_pkg::ST_RC8M_RDY] = pins[eoc_pkg::PIN_RC8M]; // RULE_01
        status[eoc_pkg::ST_FLL_SYNC] = pins[eoc_pkg::PIN_FSYNC]; // RULE_04
        status[eoc_pkg::ST_FLL_OOR] = pins[eoc_pkg::PIN_OOR]; // RULE_03
        status[eoc_pkg::ST_FLL_FINE] = pins[eoc_pkg::PIN_FINE]; // RULE_03
        status[eoc_pkg::ST_FLL_COARSE] = pins[eoc_pkg::PIN_COARSE]; // RULE_03
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_prev_r <= eoc_pkg::ST_RESET;
        end else begin
            status_prev_r <= status;
        end
    end

    // ****************************************************************
    // Interrupt status and mask
    // ****************************************************************
    logic [eoc_pkg::ST_W-1:0] int_status_r;
    logic [eoc_pkg::ST_W-1:0] int_status_nxt;
    logic [eoc_pkg::ST_W-1:0] int_mask_r;
    logic [eoc_pkg::ST_W-1:0] rise;

    assign rise = status & ~status_prev_r;

    // A rising edge in the clearing cycle survives the read
    always_comb begin
        int_status_nxt = int_status_r;
        if (rd_take && hit(wb_adr_i, eoc_pkg::ADR_INT_STATUS)) begin
            int_status_nxt = '0;
        end
        int_status_nxt = int_status_nxt | rise;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            int_status_r <= eoc_pkg::ST_RESET;
        end else begin
            int_status_r <= int_status_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            int_mask_r <= eoc_pkg::ST_RESET;
        end else if (wr_take && hit(wb_adr_i, eoc_pkg::ADR_INT_MASK) &&
                     wb_sel_i[0]) begin
            int_mask_r <= wb_dat_i[eoc_pkg::ST_W-1:0];
        end
    end

    assign irq_o = |(int_status_r & int_mask_r);

    // ****************************************************************
    // Bus answer
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_take;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= '0;
        end else if (rd_take) begin
            unique case (1'b1)
                hit(wb_adr_i, eoc_pkg::ADR_STATUS):
                    wb_dat_o <= {24'h000000, status};
                hit(wb_adr_i, eoc_pkg::ADR_CONTROL):
                    wb_dat_o <= {16'h0000, ctrl_r};
                hit(wb_adr_i, eoc_pkg::ADR_INT_STATUS):
                    wb_dat_o <= {24'h000000, int_status_r};
                hit(wb_adr_i, eoc_pkg::ADR_INT_MASK):
                    wb_dat_o <= {24'h000000, int_mask_r};
                default:
                    wb_dat_o <= '0;
            endcase
        end
    end

endmodule // eoc_top
`default_nettype wire

//--- verification/eoc_monitor.sv
// Port-level assertions for the external oscillator control block
`timescale 1ns/1ps
`default_nettype none
module eoc_monitor (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic osc_run_o,
    input wire logic crystal_select_o,
    input wire logic osc_out_pin_free_o,
    input wire logic auto_gain_ctrl_o,
    input wire logic [eoc_pkg::GAIN_W-1:0] osc_gain_o,
    input wire logic ext_osc_ready_o
);
    // ****************************************************************
    // Cycles the oscillator has run without a break
    // ****************************************************************
    logic [4:0] run_cnt_r;
    always_ff @(posedge clk_i) begin
        if (rst_i || !osc_run_o) begin
            run_cnt_r <= 5'h00;
        end else if (run_cnt_r != 5'h1F) begin
            run_cnt_r <= run_cnt_r + 5'h01;
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_taken;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_run_off;
        !osc_run_o ##1 !osc_run_o;
    endsequence

    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_ack_follows_req: assert property (s_taken |=> wb_ack_o)
        else $error("bus request not answered next cycle");
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge longer than one cycle");
    a_no_stray_ack: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("acknowledge without request");
    a_read_data_holds: assert property (!wb_ack_o |-> $stable(wb_dat_o))
        else $error("read data changed outside an answer");
    a_ready_drops_stop: assert property (!osc_run_o |=> !ext_osc_ready_o)
        else $error("ready kept after oscillator stop");
    a_ready_after_settle: assert property ($rose(ext_osc_ready_o) |-> run_cnt_r >= 5'h10)
        else $error("ready too soon after oscillator start");
    a_auto_gain_off: assert property (s_run_off |-> !auto_gain_ctrl_o)
        else $error("auto gain active while stopped");
    a_gain_frozen_auto: assert property (auto_gain_ctrl_o && $past(auto_gain_ctrl_o) |-> $stable(osc_gain_o))
        else $error("gain moved under auto gain");
    a_out_pin_free: assert property (osc_out_pin_free_o == !crystal_select_o)
        else $error("output pin freedom wrong");
endmodule // eoc_monitor

bind eoc_top eoc_monitor eoc_monitor_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .osc_run_o(osc_run_o),
    .crystal_select_o(crystal_select_o),
    .osc_out_pin_free_o(osc_out_pin_free_o),
    .auto_gain_ctrl_o(auto_gain_ctrl_o), .osc_gain_o(osc_gain_o),
    .ext_osc_ready_o(ext_osc_ready_o));
`default_nettype wire

//--- verification/eoc_xtal_model.sv
// Behavioural crystal or external clock feeding the oscillator input pin
`timescale 1ns/1ps
`default_nettype none
module eoc_xtal_model (
    input wire logic run_i,
    input wire logic slow_i,
    output logic osc_in_pin_o
);
    // ****************************************************************
    // Oscillates only while the device runs it, else rests low
    // ****************************************************************
    initial begin
        osc_in_pin_o = 1'b0;
        forever begin
            if (run_i === 1'b1) begin
                #(slow_i ? 120 : 40);
                osc_in_pin_o = ~osc_in_pin_o;
            end else begin
                osc_in_pin_o = 1'b0;
                @(run_i);
            end
        end
    end
endmodule // eoc_xtal_model
`default_nettype wire

//--- verification/ext_osc_control_status_tb_top.sv
// Self-checking bench for the external oscillator control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin n_checks++; if ((got) !== (exp)) begin \
    n_errors++; $display("mismatch %s expected %h seen %h", what, exp, got); \
    end end
module ext_osc_control_status_tb_top;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, d;
    logic wp, ulp, osc_in, req, stby, slow, run, xsel, pfree, agc, rdy;
    logic [7:1] st_in, acc;
    logic [2:0] gain;
    logic [63:0] exp_q[$];
    logic [63:0] note;
    int n_errors = 0;
    int n_checks = 0;
    int k;

    eoc_top eoc_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .write_protect_i(wp),
        .ultra_low_power_32k_i(ulp), .osc_in_pin_i(osc_in),
        .periph_req_i(req), .standby_i(stby), .rc8m_ready_i(st_in[3]),
        .rc32k_ready_i(st_in[2]), .crystal32k_ready_i(st_in[1]),
        .fll_coarse_lock_i(st_in[7]), .fll_fine_lock_i(st_in[6]),
        .fll_out_of_range_i(st_in[5]), .fll_sync_ready_i(st_in[4]),
        .osc_run_o(run), .crystal_select_o(xsel), .osc_out_pin_free_o(pfree),
        .auto_gain_ctrl_o(agc), .osc_gain_o(gain), .ext_osc_ready_o(rdy),
        .irq_o(irq_o));
    eoc_xtal_model eoc_xtal_model_inst (.run_i(run), .slow_i(slow),
        .osc_in_pin_o(osc_in));

    always #4 clk_i = ~clk_i;
    always #203 ulp = ~ulp;

    // ****************************************************************
    // Bus cycles and checking of read answers
    // ****************************************************************
    task automatic bus(input logic we, input logic [7:0] a,
                       input logic [31:0] v, input logic [31:0] m);
        int i;
        if (!we) exp_q.push_back({m, v & m});
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= 4'hF;
        wb_adr_i <= a;
        wb_dat_i <= we ? v : 32'h00000000;
        i = 0;
        do begin
            @(posedge clk_i);
            i++;
        end while (wb_ack_o !== 1'b1 && i < 100);
        if (i >= 100) n_errors++;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        bus(1'b1, a, v, 32'h00000000);
    endtask

    task automatic wait_ready();
        for (int i = 0; i < 3000 && rdy !== 1'b1; i++) @(posedge clk_i);
    endtask

    always @(posedge clk_i) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) begin
            note = exp_q.pop_front();
            `CHK("read data", note[31:0], wb_dat_o & note[63:32])
        end
    end

    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    initial begin
        #(8 * 60000);
        n_errors++;
        summarize();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        {clk_i, wb_cyc_i, wb_stb_i, wb_we_i, wp, ulp, req, stby, slow} = '0;
        rst_i = 1'b1;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h00000000;
        st_in = 7'h00;
        acc = 7'h00;
        void'($urandom(32'hDD69FDC7));
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b0, eoc_pkg::ADR_CONTROL, 32'h00000080, 32'hFFFFFFFF);
        bus(1'b0, 8'h04, 32'h00000000, 32'hFFFFFFFF);
        `CHK("pin free", 1'b1, pfree)
        for (k = 0; k < 4; k++) begin
            d = $urandom();
            acc = acc | (d[6:0] & ~st_in);
            st_in <= d[6:0];
            repeat (10) @(posedge clk_i);
            bus(1'b0, eoc_pkg::ADR_STATUS, {st_in, 1'b0}, 32'hFF);
        end
        st_in <= 7'h00;
        repeat (10) @(posedge clk_i);
        bus(1'b0, eoc_pkg::ADR_INT_STATUS, {acc, 1'b0}, 32'hFF);
        wr(eoc_pkg::ADR_INT_MASK, 32'h00000008);
        st_in <= 7'h04;
        repeat (10) @(posedge clk_i);
        `CHK("irq raised", 1'b1, irq_o)
        wr(eoc_pkg::ADR_INT_MASK, 32'h00000000);
        repeat (2) @(posedge clk_i);
        `CHK("irq masked", 1'b0, irq_o)
        wr(eoc_pkg::ADR_INT_MASK, 32'h00000008);
        repeat (2) @(posedge clk_i);
        `CHK("irq unmasked", 1'b1, irq_o)
        bus(1'b0, eoc_pkg::ADR_INT_STATUS, 32'h8, 32'h8);
        repeat (2) @(posedge clk_i);
        `CHK("irq cleared", 1'b0, irq_o)
        wp <= 1'b1;
        wr(eoc_pkg::ADR_CONTROL, 32'h0000F706);
        bus(1'b0, eoc_pkg::ADR_CONTROL, 32'h00000080, 32'hFFFFFFFF);
        wp <= 1'b0;
        d = $urandom() & 32'h0000F7FD;
        wr(eoc_pkg::ADR_CONTROL, d);
        bus(1'b0, eoc_pkg::ADR_CONTROL, d & 32'h0000FFC6, 32'hFFFFFFFF);
        for (k = 0; k < 8; k++) begin
            wr(eoc_pkg::ADR_CONTROL, 32'(k) << 8);
            repeat (3) @(posedge clk_i);
            `CHK("gain", 3'(k), gain)
        end
        wr(eoc_pkg::ADR_CONTROL, 32'h00000306);
        repeat (4) @(posedge clk_i);
        `CHK("run enabled", 1'b1, run)
        `CHK("crystal", 1'b1, xsel)
        `CHK("pin used", 1'b0, pfree)
        wait_ready();
        `CHK("ready", 1'b1, rdy)
        bus(1'b0, eoc_pkg::ADR_STATUS, 32'h1, 32'h1);
        wr(eoc_pkg::ADR_CONTROL, 32'h00000B06);
        repeat (3) @(posedge clk_i);
        `CHK("auto gain on", 1'b1, agc)
        wr(eoc_pkg::ADR_CONTROL, 32'h00000906);
        repeat (3) @(posedge clk_i);
        `CHK("gain frozen", 3'h3, gain)
        wr(eoc_pkg::ADR_CONTROL, 32'h00000106);
        repeat (3) @(posedge clk_i);
        `CHK("gain free", 3'h1, gain)
        `CHK("auto gain off", 1'b0, agc)
        wr(eoc_pkg::ADR_CONTROL, 32'h00000086);
        repeat (3) @(posedge clk_i);
        `CHK("run no request", 1'b0, run)
        `CHK("ready cleared", 1'b0, rdy)
        req <= 1'b1;
        repeat (2) @(posedge clk_i);
        `CHK("request synced", 1'b0, run)
        repeat (10) @(posedge clk_i);
        `CHK("run on request", 1'b1, run)
        stby <= 1'b1;
        repeat (10) @(posedge clk_i);
        `CHK("standby stop", 1'b0, run)
        wr(eoc_pkg::ADR_CONTROL, 32'h000020C6);
        repeat (3) @(posedge clk_i);
        `CHK("standby kept", 1'b1, run)
        req <= 1'b0;
        repeat (10) @(posedge clk_i);
        `CHK("standby on request", 1'b0, run)
        slow <= 1'b1;
        req <= 1'b1;
        stby <= 1'b0;
        repeat (100) @(posedge clk_i);
        `CHK("ready held", 1'b0, rdy)
        wait_ready();
        `CHK("ready again", 1'b1, rdy)
        summarize();
    end
endmodule // ext_osc_control_status_tb_top
`default_nettype wire
